// [rtl/stack_link_pkg.sv]
// package: constants and carrier types for the stack link layer
package stack_link_pkg;
   localparam int unsigned clk_mhz = 250;
   localparam int unsigned dwell_ns = 240;
   // least time: round up
   localparam int unsigned dwell_cycles = (dwell_ns * clk_mhz + 999) / 1000;
   localparam int unsigned idle_timeout_us = 4300;
   localparam int unsigned idle_timeout_cycles = idle_timeout_us * clk_mhz;
   localparam int unsigned wake_time_us = 400;
   localparam int unsigned wake_time_cycles = wake_time_us * clk_mhz;
   localparam int unsigned ready_time_us = 10;
   localparam int unsigned ready_time_cycles = ready_time_us * clk_mhz;
   localparam logic [14:0] check_seed = 15'h0010;
   localparam logic [14:0] check_poly = 15'h4599;
   localparam logic [3:0] byte_bits = 4'h8;
   localparam int unsigned data_group_bytes = 6;
   localparam logic [2:0] group_len = 3'h6;
   localparam logic [3:0] cmd_bytes = 4'h4;
   localparam logic [3:0] wr_group_bytes = 4'h8;
   localparam logic [7:0] read_opcode_low = 8'h02;

   typedef enum logic [1:0] {
      pulse_long_pos, pulse_long_neg, pulse_short_pos, pulse_short_neg
   } pulse_kind_type;

   typedef struct packed {
      logic valid;
      pulse_kind_type kind;
   } pulse_req_type;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic sdi;
   } lower_in_type;

   typedef enum {st_idle, st_waking, st_ready} link_state_type;
   typedef enum {ph_cmd, ph_read, ph_write, ph_skip} phase_type;
endpackage

// [rtl/stack_link_wake_and_pec.sv]
// stack link layer: wake, idle timing, byte framing, check code, chain order
//
// What this block does
// - idle ports after quiet idle timeout
// - wake on activity at either port
// - wake needs difference held dwell time
// - ready within wake or ready time
// - send long positive pulse upward when ready
// - already ready: do not forward wake
// - whole bytes, most significant bit first
// - write data captured at chip-select rise
// - decode read after check, data next edge
// - fifteen-bit check code, fixed polynomial, seed
// - feedback is input xor top bit
// - check word is code with zero appended
// - accept only when check code matches
// - append own check code to read data
// - high byte bits 14..7, low byte rest
// - own group first, then upper data
// - mode pin picks spi or pulse link
// - cs edges long pulses, data short pulses
`timescale 1ns/1ps
module stack_link_wake_and_pec #(
   parameter int unsigned idle_cycles = stack_link_pkg::idle_timeout_cycles,
   parameter int unsigned wake_cycles = stack_link_pkg::wake_time_cycles,
   parameter int unsigned ready_cycles = stack_link_pkg::ready_time_cycles
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic port_mode_select_pin,
   input wire logic core_standby,
   input wire logic chip_select_n,
   input wire logic sck,
   input wire logic sdi,
   input wire logic lower_wake_diff,
   input wire logic upper_wake_diff,
   input wire logic upper_sdo,
   input wire logic [47:0] read_data,
   output logic sdo,
   output logic link_ready,
   output logic link_idle,
   output stack_link_pkg::pulse_req_type upper_pulse,
   output logic [47:0] write_data,
   output logic write_strobe,
   output logic check_error
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      stack_link_pkg::lower_in_type s1;
      stack_link_pkg::lower_in_type s2;
      logic [1:0] wk1;
      logic [1:0] wk2;
      logic [1:0] mode_sync;
      logic usdo1;
      logic usdo2;
      logic cs_n_old;
      logic sck_old;
      stack_link_pkg::link_state_type st;
      logic [31:0] idle_cnt;
      logic [31:0] wake_cnt;
      logic [7:0] dwell_cnt;
      stack_link_pkg::phase_type ph;
      logic [3:0] bit_cnt;
      logic [3:0] byte_cnt;
      logic [7:0] shreg;
      logic [7:0] prev_byte;
      logic [14:0] crc;
      logic [15:0] cmd;
      logic [63:0] rx_grp;
      logic [63:0] tx_grp;
      logic [6:0] tx_bits;
      logic wr_ok;
      logic sdo;
      stack_link_pkg::pulse_req_type pulse;
      logic [47:0] wdata;
      logic wstb;
      logic cerr;
   } state_type;

   state_type q, d;

   // one bit of the check register: feedback into the tap positions
   function automatic logic [14:0] crc_step(input logic [14:0] c,
                                            input logic din);
      logic fb;
      fb = din ^ c[14];
      crc_step = {c[13:0], 1'b0} ^ (fb ? stack_link_pkg::check_poly
                                        : 15'h0000);
   endfunction

   function automatic logic [14:0] crc_word(input logic [47:0] w);
      logic [14:0] c;
      c = stack_link_pkg::check_seed;
      for (int i = 47; i >= 0; i--) begin
         c = crc_step(c, w[i]);
      end
      crc_word = c;
   endfunction

   function automatic logic [14:0] crc_cmd(input logic [15:0] w);
      logic [14:0] c;
      c = stack_link_pkg::check_seed;
      for (int i = 15; i >= 0; i--) begin
         c = crc_step(c, w[i]);
      end
      crc_cmd = c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic cs_rise, cs_fall, sck_rise, diff_act, activity, chk_match;
   logic [7:0] rx_byte;
   logic [15:0] own_word;
   logic [14:0] own_crc;

   always_comb begin
      cs_rise = q.s2.cs_n & ~q.cs_n_old;
      cs_fall = ~q.s2.cs_n & q.cs_n_old;
      sck_rise = q.s2.sck & ~q.sck_old & ~q.s2.cs_n;
      // common mode never reaches these comparator outputs
      diff_act = q.wk2[0] | q.wk2[1];
      if (q.mode_sync[1]) begin
         activity = q.dwell_cnt >= 8'(stack_link_pkg::dwell_cycles);
      end else begin
         activity = cs_rise | cs_fall | sck_rise |
                    (q.dwell_cnt >= 8'(stack_link_pkg::dwell_cycles)
                     & q.wk2[1]);
      end
      rx_byte = {q.shreg[6:0], q.s2.sdi};
      chk_match = {q.prev_byte, rx_byte} == {q.crc, 1'b0};
      own_crc = crc_word(read_data);
      own_word = {own_crc, 1'b0};
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      d.s1 = '{cs_n: chip_select_n, sck: sck, sdi: sdi};
      d.s2 = q.s1;
      d.wk1 = {upper_wake_diff, lower_wake_diff};
      d.wk2 = q.wk1;
      d.mode_sync = {q.mode_sync[0], port_mode_select_pin};
      d.usdo1 = upper_sdo;
      d.usdo2 = q.usdo1;
      d.cs_n_old = q.s2.cs_n;
      d.sck_old = q.s2.sck;
      d.pulse = '{valid: 1'b0, kind: stack_link_pkg::pulse_long_pos};
      d.wstb = 1'b0;
      d.cerr = 1'b0;
      // dwell filter on the differential detector
      if (diff_act) begin
         if (q.dwell_cnt != 8'hff) begin
            d.dwell_cnt = q.dwell_cnt + 8'h01;
         end
      end else begin
         d.dwell_cnt = 8'h00;
      end
      if (activity) begin
         d.dwell_cnt = 8'h00;
      end

      case (q.st)
         stack_link_pkg::st_idle: begin
            if (activity) begin
               d.st = stack_link_pkg::st_waking;
               d.wake_cnt = core_standby ? 32'(ready_cycles)
                                         : 32'(wake_cycles);
            end
         end
         stack_link_pkg::st_waking: begin
            if (q.wake_cnt <= 32'h1) begin
               d.st = stack_link_pkg::st_ready;
               d.idle_cnt = 32'h0;
               // only the idle-to-ready path forwards a wake
               d.pulse = '{valid: 1'b1,
                           kind: stack_link_pkg::pulse_long_pos};
            end else begin
               d.wake_cnt = q.wake_cnt - 32'h1;
            end
         end
         stack_link_pkg::st_ready: begin
            if (activity) begin
               d.idle_cnt = 32'h0;
            end else if (q.idle_cnt >= 32'(idle_cycles) - 32'h1) begin
               d.st = stack_link_pkg::st_idle;
            end else begin
               d.idle_cnt = q.idle_cnt + 32'h1;
            end
            // relay lower port events up the chain
            if (cs_rise) begin
               d.pulse = '{valid: 1'b1,
                           kind: stack_link_pkg::pulse_long_pos};
            end else if (cs_fall) begin
               d.pulse = '{valid: 1'b1,
                           kind: stack_link_pkg::pulse_long_neg};
            end else if (sck_rise) begin
               d.pulse = '{valid: 1'b1,
                           kind: q.s2.sdi ? stack_link_pkg::pulse_short_pos
                                   : stack_link_pkg::pulse_short_neg};
            end
         end
         default: d.st = stack_link_pkg::st_idle;
      endcase

      // framing: clock edges count only while ready; cs fall resets framing in any state, so a frame opened during wake stays open
      if (cs_fall) begin
         d.ph = stack_link_pkg::ph_cmd;
         d.bit_cnt = 4'h0;
         d.byte_cnt = 4'h0;
         d.crc = stack_link_pkg::check_seed;
         d.wr_ok = 1'b0;
      end
      if (sck_rise && q.st == stack_link_pkg::st_ready) begin
         // shift out on the same edge that shifts in
         if (q.ph == stack_link_pkg::ph_read) begin
            if (q.tx_bits != 7'h0) begin
               d.sdo = q.tx_grp[63];
               d.tx_grp = {q.tx_grp[62:0], 1'b0};
               d.tx_bits = q.tx_bits - 7'h01;
            end else begin
               d.sdo = q.usdo2;
            end
         end
         d.shreg = rx_byte;
         d.bit_cnt = q.bit_cnt + 4'h1;
         // check bytes of a group stay out of the running code
         if (q.byte_cnt < 4'h2 || (q.ph == stack_link_pkg::ph_write &&
             q.byte_cnt < 4'(stack_link_pkg::data_group_bytes))) begin
            d.crc = crc_step(q.crc, q.s2.sdi);
         end
         if (q.bit_cnt == stack_link_pkg::byte_bits - 4'h1) begin
            d.bit_cnt = 4'h0;
            d.byte_cnt = q.byte_cnt + 4'h1;
            d.prev_byte = rx_byte;
            if (q.ph == stack_link_pkg::ph_cmd) begin
               d.cmd = q.byte_cnt < 4'h2 ? {q.cmd[7:0], rx_byte} : q.cmd;
               if (q.byte_cnt == 4'h2) begin
                  d.cmd = q.cmd;
               end
               if (q.byte_cnt == stack_link_pkg::cmd_bytes - 4'h1) begin
                  d.byte_cnt = 4'h0;
                  d.crc = stack_link_pkg::check_seed;
                  // compare received check word with computed
                  if (chk_match) begin
                     if (q.cmd[7:0] == stack_link_pkg::read_opcode_low) begin
                        d.ph = stack_link_pkg::ph_read;
                        d.tx_grp = {read_data, own_word};
                        d.tx_bits = 7'h40;
                     end else begin
                        d.ph = stack_link_pkg::ph_write;
                     end
                  end else begin
                     d.ph = stack_link_pkg::ph_skip;
                     d.cerr = 1'b1;
                  end
               end
            end else if (q.ph == stack_link_pkg::ph_write) begin
               // last group received is this device's own
               d.rx_grp = {q.rx_grp[55:0], rx_byte};
               if (q.byte_cnt == stack_link_pkg::wr_group_bytes - 4'h1) begin
                  d.byte_cnt = 4'h0;
                  d.wr_ok = chk_match;
                  d.crc = stack_link_pkg::check_seed;
               end
            end
         end
      end
      if (cs_rise) begin
         d.sdo = 1'b1;
         if (q.ph == stack_link_pkg::ph_write) begin
            if (q.wr_ok && q.byte_cnt == 4'h0) begin
               d.wdata = q.rx_grp[63:16];
               d.wstb = 1'b1;
            end else if (q.byte_cnt != 4'h0 || !q.wr_ok) begin
               d.cerr = 1'b1;
            end
         end
         d.ph = stack_link_pkg::ph_skip;
      end
      if (!resetn) begin
         d.st = stack_link_pkg::st_idle;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         q <= '0;
         q.s1 <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
         q.s2 <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
         q.cs_n_old <= 1'b1;
         q.st <= stack_link_pkg::st_idle;
         q.ph <= stack_link_pkg::ph_skip;
         q.crc <= stack_link_pkg::check_seed;
         q.sdo <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign sdo = q.sdo;
   assign link_ready = q.st == stack_link_pkg::st_ready;
   assign link_idle = q.st == stack_link_pkg::st_idle;
   assign upper_pulse = q.pulse;
   assign write_data = q.wdata;
   assign write_strobe = q.wstb;
   assign check_error = q.cerr;

   ////////////////////////////////////////////////////////////////////////
   a_pec_example: assert property (
      @(posedge core_clk) {crc_cmd(16'h0001), 1'b0} == 16'h3d6e)
      else $error("check code example wrong");
   a_wake_pulse: assert property (
      @(posedge core_clk) disable iff (!resetn)
      $past(q.st) == stack_link_pkg::st_waking && link_ready
      |-> upper_pulse.valid)
      else $error("no wake pulse upward");
   a_ready_no_fwd: assert property (
      @(posedge core_clk) disable iff (!resetn)
      $past(link_ready) && link_ready && !$past(cs_rise) && !$past(cs_fall)
      && !$past(sck_rise) |-> !upper_pulse.valid)
      else $error("ready device forwarded pulse");
   a_idle_quiet: assert property (
      @(posedge core_clk) disable iff (!resetn)
      link_ready ##1 link_idle
      |-> $past(q.idle_cnt) == 32'(idle_cycles) - 32'h1)
      else $error("idle without quiet");
   a_act_restart: assert property (
      @(posedge core_clk) disable iff (!resetn)
      link_ready && activity |=> link_ready && q.idle_cnt == 32'h0)
      else $error("idle timer not restarted");
   a_wake_start: assert property (
      @(posedge core_clk) disable iff (!resetn)
      link_idle && activity |=> q.st == stack_link_pkg::st_waking)
      else $error("activity did not wake");
   a_write_edge: assert property (
      @(posedge core_clk) disable iff (!resetn)
      write_strobe |-> $past(cs_rise))
      else $error("write outside chip select rise");
   a_short_dwell: assert property (
      @(posedge core_clk) disable iff (!resetn)
      q.mode_sync[1] && link_idle
      && q.dwell_cnt < 8'(stack_link_pkg::dwell_cycles - 1)
      |=> q.st != stack_link_pkg::st_waking)
      else $error("wake before dwell time");
   a_own_first: assert property (
      @(posedge core_clk) disable iff (!resetn)
      sck_rise && link_ready && q.ph == stack_link_pkg::ph_read
      && q.tx_bits != 7'h00 |=> sdo == $past(q.tx_grp[63]))
      else $error("own group not shifted first");
   c_wake: cover property (@(posedge core_clk) link_idle ##[1:5] !link_idle);
   c_write: cover property (@(posedge core_clk) write_strobe);
   c_err: cover property (@(posedge core_clk) check_error);
   c_read: cover property (@(posedge core_clk)
      q.ph == stack_link_pkg::ph_read && q.tx_bits == 7'h00);
   c_pulse_wake: cover property (@(posedge core_clk)
      q.mode_sync[1] && link_ready);
endmodule

// [bench/upper_chain_model.sv]
// upper neighbour model: shifts its own stream down the chain on reads
`timescale 1ns/1ps
module upper_chain_model #(
   parameter logic [63:0] pattern = 64'ha5c3_0f96_e178_3c4b
) (
   input wire logic chip_select_n,
   input wire logic sck,
   output logic upper_sdo
);
   logic [63:0] sh = pattern;
   logic idle_level = 1'b1;
   int rises = 0;

   ////////////////////////////////////////////////////////////////////////
   always @(negedge chip_select_n) begin
      sh = pattern;
      rises = 0;
   end

   always @(posedge sck) begin
      if (!chip_select_n) begin
         rises++;
      end
   end

   // own 64 bits below come first, so wait past command and that group
   always @(negedge sck) begin
      if (!chip_select_n && rises >= 97) begin
         sh = {sh[62:0], ~sh[63]};
      end
   end

   // released line: never leave the last value showing
   always @(posedge chip_select_n) begin
      idle_level = ~sh[63];
   end

   assign upper_sdo = chip_select_n ? idle_level : sh[63];
endmodule

// [bench/tb_stack_link_wake_and_pec.sv]
// testbench: wake, idle, framing, check code and chain order scenarios
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, a, e); end end
module tb_stack_link_wake_and_pec;
   localparam int unsigned idle_n = 2000;
   localparam int unsigned wake_n = 100;
   localparam int unsigned ready_n = 20;
   localparam logic [63:0] pat = 64'ha5c3_0f96_e178_3c4b;
   localparam logic [47:0] rd = 48'h1f2e_3d4c_5b6a;
   localparam logic [47:0] gs = 48'h0102_0304_0506;
   localparam logic [47:0] gp = 48'hf0e1_d2c3_b4a5;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic core_standby = 1'b0;
   logic chip_select_n = 1'b1;
   logic sck = 1'b0;
   logic sdi = 1'b0;
   logic upper_wake_diff = 1'b0;
   logic lower_wake_diff = 1'b0;
   logic port_mode_select_pin = 1'b0;
   logic upper_sdo, sdo, link_ready, link_idle, write_strobe, check_error;
   stack_link_pkg::pulse_req_type upper_pulse;
   logic [47:0] write_data;
   logic [63:0] rx;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   int kinds [4] = '{0, 0, 0, 0};
   int strobes = 0;
   int errors = 0;

   ////////////////////////////////////////////////////////////////////////
   // short counts keep the run small
   stack_link_wake_and_pec #(.idle_cycles(idle_n), .wake_cycles(wake_n),
      .ready_cycles(ready_n)) dut_u (.core_clk(core_clk), .resetn(resetn),
      .port_mode_select_pin(port_mode_select_pin),
      .core_standby(core_standby),
      .chip_select_n(chip_select_n), .sck(sck), .sdi(sdi),
      .lower_wake_diff(lower_wake_diff), .upper_wake_diff(upper_wake_diff),
      .upper_sdo(upper_sdo), .read_data(rd), .sdo(sdo),
      .link_ready(link_ready), .link_idle(link_idle),
      .upper_pulse(upper_pulse), .write_data(write_data),
      .write_strobe(write_strobe), .check_error(check_error));

   upper_chain_model #(.pattern(pat)) partner_u (
      .chip_select_n(chip_select_n), .sck(sck), .upper_sdo(upper_sdo));

   always #2 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cycles++;
      if (upper_pulse.valid === 1'b1) kinds[upper_pulse.kind]++;
      if (write_strobe === 1'b1) strobes++;
      if (check_error === 1'b1) errors++;
      if (cycles == 40000) begin
         miscompares++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [14:0] crc(input logic [47:0] v, input int n);
      logic [14:0] c;
      logic f;
      c = 15'h0010;
      for (int i = n - 1; i >= 0; i--) begin
         f = v[i] ^ c[14];
         c = {c[13:0], 1'b0};
         if (f) c = c ^ 15'h4599;
      end
      return c;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // link clock period 80 ns: ten core cycles each half
   task automatic bit_io(input logic b);
      sdi = b;
      cyc(10);
      sck = 1'b1;
      cyc(10);
      rx = {rx[62:0], sdo};
      sck = 1'b0;
   endtask

   task automatic send(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) bit_io(w[i]);
   endtask

   task automatic send_cmd(input logic [15:0] c, input logic bad);
      send(c);
      send({crc({32'h0, c}, 16) ^ {14'h0, bad}, 1'b0});
   endtask

   task automatic send_group(input logic [47:0] g, input logic bad);
      for (int i = 47; i >= 0; i--) bit_io(g[i]);
      send({crc(g, 48) ^ {14'h0, bad}, 1'b0});
   endtask

   task automatic cs(input logic v);
      chip_select_n = v;
      cyc(10);
   endtask

   task automatic wait_ready(input int lim);
      int n;
      n = 0;
      while (link_ready !== 1'b1 && n < lim) begin
         cyc(1);
         n++;
      end
      `CHK(link_ready, 1'b1)
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_dwell;
      upper_wake_diff = 1'b1;
      cyc(50);
      upper_wake_diff = 1'b0;
      cyc(200);
      `CHK(link_ready, 1'b0)
      upper_wake_diff = 1'b1;
      cyc(70);
      upper_wake_diff = 1'b0;
      wait_ready(wake_n + 12);
      cyc(10);
      `CHK(kinds[0], 1)
      `CHK(link_idle, 1'b0)
      upper_wake_diff = 1'b1;
      cyc(70);
      upper_wake_diff = 1'b0;
      cyc(wake_n + 20);
      `CHK(kinds[0], 1)
   endtask

   task automatic t_read;
      int k [4];
      int ones;
      k = kinds;
      ones = $countones({16'h0002, crc({32'h0, 16'h0002}, 16)});
      cs(0);
      send_cmd(16'h0002, 1'b0);
      repeat (64) bit_io(1'b0);
      `CHK(rx, {rd, crc(rd, 48), 1'b0})
      repeat (64) bit_io(1'b0);
      `CHK(rx, pat)
      cs(1);
      `CHK(sdo, 1'b1)
      `CHK(kinds[1] - k[1], 1)
      `CHK(kinds[0] - k[0], 1)
      `CHK(kinds[2] - k[2], ones)
      `CHK(kinds[3] - k[3], 160 - ones)
   endtask

   task automatic t_write;
      int s;
      s = strobes;
      cs(0);
      send_cmd(16'h0001, 1'b0);
      send_group(gs, 1'b0);
      send_group(gp, 1'b0);
      cyc(20);
      `CHK(strobes - s, 0)
      cs(1);
      `CHK(strobes - s, 1)
      `CHK(write_data, gp)
   endtask

   // a corrupt command and then corrupt data must both be dropped
   task automatic t_bad;
      int e;
      int s;
      e = errors;
      s = strobes;
      cs(0);
      send_cmd(16'h0001, 1'b1);
      send_group(gs, 1'b0);
      cs(1);
      `CHK(errors - e, 1)
      cs(0);
      send_cmd(16'h0001, 1'b0);
      send_group(gs, 1'b1);
      cs(1);
      `CHK(errors - e, 2)
      `CHK(strobes - s, 0)
      `CHK(write_data, gp)
   endtask

   task automatic t_idle;
      cyc(1500);
      cs(0);
      cs(1);
      cyc(idle_n - 110);
      `CHK(link_idle, 1'b0)
      cyc(200);
      `CHK({link_idle, link_ready}, 2'h2)
   endtask

   task automatic t_standby;
      int e;
      e = errors;
      core_standby = 1'b1;
      cs(0);
      wait_ready(ready_n + 8);
      cyc(ready_n);
      repeat (8) bit_io(1'b0);
      cs(1);
      core_standby = 1'b0;
      `CHK(errors - e, 0)
      `CHK(link_ready, 1'b1)
   endtask

   // pulse-link mode: only a held difference wakes, pins do not
   task automatic t_pulse;
      int k0;
      cyc(idle_n + 20);
      `CHK(link_idle, 1'b1)
      k0 = kinds[0];
      port_mode_select_pin = 1'b1;
      cs(0);
      cs(1);
      `CHK(link_idle, 1'b1)
      lower_wake_diff = 1'b1;
      cyc(50);
      lower_wake_diff = 1'b0;
      cyc(200);
      `CHK(link_idle, 1'b1)
      lower_wake_diff = 1'b1;
      cyc(70);
      lower_wake_diff = 1'b0;
      wait_ready(wake_n + 12);
      cyc(10);
      `CHK(kinds[0] - k0, 1)
      port_mode_select_pin = 1'b0;
   endtask

   task automatic results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      cyc(10);
      resetn = 1'b1;
      cyc(2);
      `CHK({sdo, link_idle, link_ready}, 3'h6)
      `CHK({write_strobe, check_error}, 2'h0)
      t_dwell();
      t_read();
      t_write();
      t_bad();
      t_idle();
      t_standby();
      t_pulse();
      results();
   end
endmodule
